// ### src/iwd_decoder.sv
`timescale 1ns/10ps

`include "iwd_params.svh"

module iwd_decoder
  import iwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`IWD_WORD_W-1:0] instr_word,
  input wire logic cond_true,
  output iwd_dec_t dec_out,
  output logic [1:0] phase_out,
  output iwd_cyc_t cycle_kind,
  output logic cycle_start
);

  // ----------------------------------------------------------------
  // opcode recognition
  // ----------------------------------------------------------------
  // x positions are left as wildcards so any fill decodes the same
  function automatic iwd_op_t iwd_op_of(input logic [`IWD_WORD_W-1:0] w);
    iwd_op_t op;
    unique casez (w)
      14'b00_0111_????_????: op = OP_ADDWF;
      14'b00_0101_????_????: op = OP_ANDWF;
      14'b00_0001_1???_????: op = OP_CLRF;
      14'b00_0001_0???_????: op = OP_CLRW;
      14'b00_1001_????_????: op = OP_COMF;
      14'b00_0011_????_????: op = OP_DECF;
      14'b00_1011_????_????: op = OP_DECFSZ;
      14'b00_1010_????_????: op = OP_INCF;
      14'b00_1111_????_????: op = OP_INCFSZ;
      14'b00_0100_????_????: op = OP_IORWF;
      14'b00_1000_????_????: op = OP_MOVF;
      14'b00_0000_1???_????: op = OP_MOVWF;
      14'b00_1101_????_????: op = OP_RLF;
      14'b00_1100_????_????: op = OP_RRF;
      14'b00_0010_????_????: op = OP_SUBWF;
      14'b00_1110_????_????: op = OP_SWAPF;
      14'b00_0110_????_????: op = OP_XORWF;
      14'b00_0000_0110_0100: op = OP_CLRWDT;
      14'b00_0000_0110_0011: op = OP_SLEEP;
      14'b00_0000_0000_1001: op = OP_RETFIE;
      14'b00_0000_0000_1000: op = OP_RETURN;
      14'b01_00??_????_????: op = OP_BCF;
      14'b01_01??_????_????: op = OP_BSF;
      14'b01_10??_????_????: op = OP_BTFSC;
      14'b01_11??_????_????: op = OP_BTFSS;
      14'b10_0???_????_????: op = OP_CALL;
      14'b10_1???_????_????: op = OP_GOTO;
      14'b11_00??_????_????: op = OP_MOVLW;
      14'b11_01??_????_????: op = OP_RETLW;
      14'b11_110?_????_????: op = OP_SUBLW;
      14'b11_111?_????_????: op = OP_ADDLW;
      14'b11_1000_????_????: op = OP_IORLW;
      14'b11_1001_????_????: op = OP_ANDLW;
      14'b11_1010_????_????: op = OP_XORLW;
      // unlisted words, including the plain nop pattern, fall here
      default: op = OP_NOP;
    endcase
    return op;
  endfunction

  // ----------------------------------------------------------------
  // operand fields and per-operation effects
  // ----------------------------------------------------------------
  iwd_fields_t fields_now;
  iwd_dec_t dec_now;
  iwd_state_t st_reg;
  iwd_state_t st_next;

  iwd_field_split u_fields (
    .word(instr_word),
    .fields(fields_now)
  );

  // effects of the operation the word names, before registering
  always_comb begin
    dec_now = '0;
    dec_now.op = iwd_op_of(instr_word);
    dec_now.fld = fields_now;
    // control words sit in the byte group but carry no file operand
    unique case (dec_now.op)
      OP_NOP, OP_CLRWDT, OP_SLEEP, OP_RETFIE, OP_RETURN: dec_now.iclass = CLS_LIT;
      OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS: dec_now.iclass = CLS_BIT;
      OP_CALL, OP_GOTO, OP_MOVLW, OP_RETLW, OP_SUBLW, OP_ADDLW, OP_IORLW, OP_ANDLW, OP_XORLW:
        dec_now.iclass = CLS_LIT;
      default: dec_now.iclass = CLS_BYTE;
    endcase
    if (dec_now.iclass != CLS_BYTE) begin
      dec_now.fld.dest_file = 1'b0;
    end
    unique case (dec_now.op)
      OP_CLRF, OP_MOVWF: dec_now.wr_file = 1'b1;
      OP_CLRW: dec_now.wr_w = 1'b1;
      OP_BCF, OP_BSF: begin
        dec_now.wr_file = 1'b1;
        dec_now.bit_rmw = 1'b1;
      end
      OP_BTFSC, OP_BTFSS: dec_now.cond_skip = 1'b1;
      OP_CALL, OP_GOTO, OP_RETURN, OP_RETFIE: dec_now.pc_change = 1'b1;
      OP_RETLW: begin
        dec_now.wr_w = 1'b1;
        dec_now.pc_change = 1'b1;
      end
      OP_MOVLW, OP_SUBLW, OP_ADDLW, OP_IORLW, OP_ANDLW, OP_XORLW: dec_now.wr_w = 1'b1;
      OP_NOP, OP_CLRWDT, OP_SLEEP: dec_now.wr_w = 1'b0;
      default: begin
        dec_now.wr_file = fields_now.dest_file;
        dec_now.wr_w = !fields_now.dest_file;
        dec_now.cond_skip = (dec_now.op == OP_DECFSZ) || (dec_now.op == OP_INCFSZ);
      end
    endcase
    // flags the result overwrites in the status register
    unique case (dec_now.op)
      OP_ADDWF, OP_SUBWF, OP_ADDLW, OP_SUBLW: dec_now.flag_mask = `IWD_FLAGS_ALL;
      OP_RLF, OP_RRF: dec_now.flag_mask = `IWD_FLAGS_C;
      OP_ANDWF, OP_CLRF, OP_CLRW, OP_COMF, OP_DECF, OP_INCF, OP_IORWF, OP_MOVF, OP_XORWF,
        OP_ANDLW, OP_IORLW, OP_XORLW: dec_now.flag_mask = `IWD_FLAGS_Z;
      default: dec_now.flag_mask = `IWD_FLAGS_NONE;
    endcase
    dec_now.status_dest = dec_now.wr_file && (fields_now.file_idx == `IWD_ADDR_STATUS);
    // a pc low byte write is a jump: upper byte comes from the latch
    if (dec_now.wr_file && (fields_now.file_idx == `IWD_ADDR_PC_LOW)) begin
      dec_now.pc_from_latch = 1'b1;
      dec_now.pc_change = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // quarter phases and the two-cycle sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.phase = st_reg.phase + 2'h1;
    st_next.cycle_start = (st_reg.phase == `IWD_LAST_PHASE);
    // the word is taken in the first quarter; a flush cycle drops it
    if (st_reg.phase == `IWD_FIRST_PHASE) begin
      if (st_reg.cyc == CYC_NOP) begin
        st_next.dec = '0;
      end else begin
        st_next.dec = dec_now;
      end
    end
    // test outcome is only settled in the last quarter
    if (st_reg.phase == `IWD_LAST_PHASE) begin
      unique case (st_reg.cyc)
        CYC_EXEC: begin
          if (st_reg.dec.pc_change || (st_reg.dec.cond_skip && cond_true)) begin
            st_next.cyc = CYC_NOP;
          end else begin
            st_next.cyc = CYC_EXEC;
          end
        end
        CYC_NOP: st_next.cyc = CYC_EXEC;
      endcase
    end
  end

  // synchronous reset starts in the first quarter of a normal cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dec_out = st_reg.dec;
  assign phase_out = st_reg.phase;
  assign cycle_kind = st_reg.cyc;
  assign cycle_start = st_reg.cycle_start;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic taken;
  assign taken = (st_reg.phase == 2'h1) && (st_reg.cyc == CYC_EXEC);

  sequence s_quarters;
    (st_reg.phase == 2'h0) ##1 (st_reg.phase == 2'h1) ##1 (st_reg.phase == 2'h2) ##1 (st_reg.phase == 2'h3);
  endsequence

  sequence s_jump_end;
    (st_reg.phase == 2'h3) && (st_reg.cyc == CYC_EXEC) && st_reg.dec.pc_change;
  endsequence

  a_four_quarters: assert property (
    cycle_start |-> s_quarters ##1 cycle_start)
    else $error("instruction cycle is not four clocks");

  a_jump_flush: assert property (
    s_jump_end |=> (st_reg.cyc == CYC_NOP) [*4] ##1 (st_reg.cyc == CYC_EXEC))
    else $error("pc change not followed by one flush cycle");

  a_plain_single: assert property (
    (st_reg.phase == 2'h3) && (st_reg.cyc == CYC_EXEC) && !st_reg.dec.pc_change && !st_reg.dec.cond_skip
    |=> st_reg.cyc == CYC_EXEC)
    else $error("plain instruction took a second cycle");

  a_skip_false: assert property (
    (st_reg.phase == 2'h3) && (st_reg.cyc == CYC_EXEC) && st_reg.dec.cond_skip
    && !cond_true && !st_reg.dec.pc_change |=> st_reg.cyc == CYC_EXEC)
    else $error("false test took a second cycle");

  a_flush_quiet: assert property (
    (st_reg.phase == 2'h1) && (st_reg.cyc == CYC_NOP)
    |-> (st_reg.dec.op == OP_NOP) && !st_reg.dec.wr_w && !st_reg.dec.wr_file && !st_reg.dec.pc_change)
    else $error("flush cycle is not a no-operation");

  a_class_sort: assert property (
    taken && ($past(instr_word[13:12]) == 2'b01) |-> st_reg.dec.iclass == CLS_BIT)
    else $error("bit group word not in bit class");

  a_dest_route: assert property (
    taken && (st_reg.dec.iclass == CLS_BYTE)
    |-> (st_reg.dec.wr_file == st_reg.dec.fld.dest_file) && (st_reg.dec.wr_w == !st_reg.dec.fld.dest_file))
    else $error("byte result routed against destination select");

  a_index_field: assert property (
    taken && (st_reg.dec.iclass == CLS_BYTE)
    |-> (st_reg.dec.fld.file_idx == $past(instr_word[6:0])) && (st_reg.dec.fld.dest_file == $past(instr_word[7])))
    else $error("file index or destination taken from wrong bits");

  a_bit_select: assert property (
    taken && ((st_reg.dec.op == OP_BCF) || (st_reg.dec.op == OP_BSF))
    |-> st_reg.dec.bit_rmw && st_reg.dec.wr_file && (st_reg.dec.fld.bit_mask == (8'h01 << $past(instr_word[9:7]))))
    else $error("bit operation mask or write-back wrong");

  a_literal_width: assert property (
    taken && ((st_reg.dec.op == OP_CALL) || (st_reg.dec.op == OP_GOTO))
    |-> st_reg.dec.fld.lit_wide && (st_reg.dec.fld.literal == $past(instr_word[10:0])))
    else $error("jump literal is not eleven bits");

  a_dont_care: assert property (
    taken && ($past(instr_word[13:10]) == 4'b1100) |-> st_reg.dec.op == OP_MOVLW)
    else $error("don't-care bits changed the decode");

  a_status_flags: assert property (
    taken && st_reg.dec.status_dest && (st_reg.dec.op == OP_ADDWF) |-> st_reg.dec.flag_mask == `IWD_FLAGS_ALL)
    else $error("status destination lost arithmetic flags");

  a_pc_low_reload: assert property (
    taken && st_reg.dec.wr_file && (st_reg.dec.fld.file_idx == `IWD_ADDR_PC_LOW)
    |-> st_reg.dec.pc_from_latch && st_reg.dec.pc_change)
    else $error("pc low write without latch reload");

  a_undef_nop: assert property (
    taken && ($past(instr_word[13:8]) == 6'h3b) |-> (st_reg.dec.op == OP_NOP) && !st_reg.dec.pc_change)
    else $error("undefined word not a one-cycle nop");

endmodule // iwd_decoder

// ### src/iwd_field_split.sv
`timescale 1ns/10ps

`include "iwd_params.svh"

module iwd_field_split
  import iwd_pkg::*;
(
  input wire logic [`IWD_WORD_W-1:0] word,
  output iwd_fields_t fields
);

  // ----------------------------------------------------------------
  // operand extraction
  // ----------------------------------------------------------------
  // positions are fixed per class, so all fields are cut in parallel
  always_comb begin
    fields.file_idx = word[`IWD_FILE_W-1:0];
    fields.dest_file = word[`IWD_DEST_BIT];
    fields.bit_idx = word[`IWD_BIT_LSB+2:`IWD_BIT_LSB];
    fields.bit_mask = 8'h01 << fields.bit_idx;
    // jumps carry a wide literal, everything else an 8-bit one
    fields.lit_wide = (word[13:12] == 2'b10);
    if (fields.lit_wide) begin
      fields.literal = word[`IWD_LIT_W-1:0];
    end else begin
      fields.literal = {3'h0, word[7:0]};
    end
  end

endmodule // iwd_field_split

// ### src/iwd_params.svh
`ifndef IWD_PARAMS_SVH
`define IWD_PARAMS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define IWD_WORD_W 14
`define IWD_FILE_W 7
`define IWD_LIT_W 11
`define IWD_DEST_BIT 7
`define IWD_BIT_LSB 7
`define IWD_CLASS_LSB 12

// ----------------------------------------------------------------
// instruction cycle timing, in oscillator periods
// ----------------------------------------------------------------
`define IWD_PHASES_PER_CYCLE 4
`define IWD_FIRST_PHASE 2'h0
`define IWD_LAST_PHASE 2'h3

// ----------------------------------------------------------------
// special file locations and status flag positions
// ----------------------------------------------------------------
`define IWD_ADDR_PC_LOW 7'h02
`define IWD_ADDR_STATUS 7'h03
`define IWD_FLAG_C 0
`define IWD_FLAG_HALF 1
`define IWD_FLAG_Z 2
`define IWD_FLAGS_NONE 3'h0
`define IWD_FLAGS_C 3'h1
`define IWD_FLAGS_Z 3'h4
`define IWD_FLAGS_ALL 3'h7

`endif

// ### src/iwd_pkg.sv
`include "iwd_params.svh"

package iwd_pkg;

  // ----------------------------------------------------------------
  // operation codes, one per defined instruction
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP = 6'b000000, OP_ADDWF = 6'b000001, OP_ANDWF = 6'b000010, OP_CLRF = 6'b000011,
    OP_CLRW = 6'b000100, OP_COMF = 6'b000101, OP_DECF = 6'b000110, OP_DECFSZ = 6'b000111,
    OP_INCF = 6'b001000, OP_INCFSZ = 6'b001001, OP_IORWF = 6'b001010, OP_MOVF = 6'b001011,
    OP_MOVWF = 6'b001100, OP_RLF = 6'b001101, OP_RRF = 6'b001110, OP_SUBWF = 6'b001111,
    OP_SWAPF = 6'b010000, OP_XORWF = 6'b010001, OP_BCF = 6'b010010, OP_BSF = 6'b010011,
    OP_BTFSC = 6'b010100, OP_BTFSS = 6'b010101, OP_ADDLW = 6'b010110, OP_ANDLW = 6'b010111,
    OP_CALL = 6'b011000, OP_CLRWDT = 6'b011001, OP_GOTO = 6'b011010, OP_IORLW = 6'b011011,
    OP_MOVLW = 6'b011100, OP_RETFIE = 6'b011101, OP_RETLW = 6'b011110, OP_RETURN = 6'b011111,
    OP_SLEEP = 6'b100000, OP_SUBLW = 6'b100001, OP_XORLW = 6'b100010
  } iwd_op_t;

  typedef enum logic [1:0] {
    CLS_BYTE = 2'b00,
    CLS_BIT = 2'b01,
    CLS_LIT = 2'b10
  } iwd_class_t;

  typedef enum logic {
    CYC_EXEC = 1'b0,
    CYC_NOP = 1'b1
  } iwd_cyc_t;

  // ----------------------------------------------------------------
  // raw operand fields of one word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`IWD_FILE_W-1:0] file_idx;
    logic dest_file;
    logic [2:0] bit_idx;
    logic [7:0] bit_mask;
    logic [`IWD_LIT_W-1:0] literal;
    logic lit_wide;
  } iwd_fields_t;

  // ----------------------------------------------------------------
  // full decode handed to the datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    iwd_op_t op;
    iwd_class_t iclass;
    iwd_fields_t fld;
    logic wr_w;
    logic wr_file;
    logic [2:0] flag_mask;
    logic status_dest;
    logic pc_from_latch;
    logic bit_rmw;
    logic cond_skip;
    logic pc_change;
  } iwd_dec_t;

  typedef struct packed {
    logic [1:0] phase;
    iwd_cyc_t cyc;
    logic cycle_start;
    iwd_dec_t dec;
  } iwd_state_t;

endpackage

// ### test/instr_word_decoder_tb.sv
`timescale 1ns/10ps

module instr_word_decoder_tb
  import iwd_pkg::*;
  ;
  logic core_clk;
  logic rst_n;
  logic cond_true;
  logic [13:0] instr_word;
  iwd_dec_t dec_out;
  logic [1:0] phase_out;
  iwd_cyc_t cycle_kind;
  logic cycle_start;
  int errors;
  int n_checks;
  int cycles;
  int n;

  iwd_decoder u_iwd_decoder (.core_clk(core_clk), .rst_n(rst_n), .instr_word(instr_word), .cond_true(cond_true),
    .dec_out(dec_out), .phase_out(phase_out), .cycle_kind(cycle_kind), .cycle_start(cycle_start));

  iwd_prog_mem u_iwd_prog_mem (.core_clk(core_clk), .rst_n(rst_n), .phase_out(phase_out),
    .cycle_kind(cycle_kind), .instr_word(instr_word));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // whole run needs well under 300 clocks; limit leaves a wide margin
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // counts falling edges until the wanted phase; bounded so a stuck phase ends it
  task automatic wait_ph(input logic [1:0] p);
    n = 1;
    @(negedge core_clk);
    while (phase_out !== p && n < 20) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // loads a short program, resets, and stops at the first decode
  task automatic start(input logic [13:0] p [6], input logic c);
    for (int i = 0; i < 16; i++) begin
      u_iwd_prog_mem.mem[i] = (i < 6) ? p[i] : 14'h0000;
    end
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    cond_true = c;
    rst_n = 1'b1;
    wait_ph(2'h1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_byte();
    start('{14'h07ff, 14'h0500, 14'h0183, 14'h0082, 14'h0ba0, 14'h0000}, 1'b0);
    chk(dec_out.op, OP_ADDWF);
    chk(dec_out.iclass, CLS_BYTE);
    chk(dec_out.fld.file_idx, 7'h7f);
    chk(dec_out.fld.dest_file, 1'b1);
    chk({dec_out.wr_w, dec_out.wr_file}, 2'b01);
    chk(dec_out.flag_mask, 3'h7);
    wait_ph(2'h1);
    chk(n, 4);
    chk(dec_out.op, OP_ANDWF);
    chk(dec_out.fld.file_idx, 7'h00);
    chk({dec_out.fld.dest_file, dec_out.wr_w, dec_out.wr_file}, 3'b010);
    wait_ph(2'h1);
    chk(dec_out.op, OP_CLRF);
    chk({dec_out.status_dest, dec_out.flag_mask}, 4'hc);
    wait_ph(2'h1);
    chk(dec_out.op, OP_MOVWF);
    chk({dec_out.pc_change, dec_out.pc_from_latch, dec_out.wr_file}, 3'b111);
    wait_ph(2'h1);
    chk(cycle_kind, CYC_NOP);
    chk(dec_out, 49'h0);
    wait_ph(2'h1);
    chk(dec_out.op, OP_DECFSZ);
    chk({dec_out.cond_skip, dec_out.wr_file, dec_out.fld.file_idx}, {2'b11, 7'h20});
    // test is false here, so the skip must not add a flush cycle
    wait_ph(2'h1);
    chk(n, 4);
    chk(cycle_kind, CYC_EXEC);
  endtask

  task automatic t_bit();
    start('{14'h17a5, 14'h1003, 14'h1d90, 14'h0060, 14'h0000, 14'h0000}, 1'b1);
    chk(dec_out.op, OP_BSF);
    chk(dec_out.iclass, CLS_BIT);
    chk({dec_out.fld.bit_idx, dec_out.fld.bit_mask}, {3'h7, 8'h80});
    chk(dec_out.fld.file_idx, 7'h25);
    chk({dec_out.bit_rmw, dec_out.wr_file, dec_out.fld.dest_file}, 3'b110);
    wait_ph(2'h1);
    chk(dec_out.op, OP_BCF);
    chk({dec_out.fld.bit_idx, dec_out.fld.bit_mask, dec_out.fld.file_idx}, {3'h0, 8'h01, 7'h03});
    chk(dec_out.bit_rmw, 1'b1);
    wait_ph(2'h1);
    chk(dec_out.op, OP_BTFSS);
    chk({dec_out.cond_skip, dec_out.fld.bit_idx, dec_out.fld.file_idx}, {1'b1, 3'h3, 7'h10});
    wait_ph(2'h1);
    chk(cycle_kind, CYC_NOP);
    chk(dec_out.op, OP_NOP);
    wait_ph(2'h1);
    chk(n, 4);
    chk(cycle_kind, CYC_EXEC);
    chk(dec_out.op, OP_NOP);
    wait_ph(2'h1);
    chk(cycle_kind, CYC_EXEC);
  endtask

  task automatic t_lit();
    start('{14'h33a5, 14'h2fff, 14'h2555, 14'h3b00, 14'h0000, 14'h0000}, 1'b1);
    chk(dec_out.op, OP_MOVLW);
    chk({dec_out.iclass, dec_out.wr_w}, {CLS_LIT, 1'b1});
    chk({dec_out.fld.lit_wide, dec_out.fld.literal}, 12'h0a5);
    wait_ph(2'h1);
    chk(n, 4);
    chk(dec_out.op, OP_GOTO);
    chk({dec_out.fld.lit_wide, dec_out.fld.literal, dec_out.pc_change}, {1'b1, 11'h7ff, 1'b1});
    wait_ph(2'h0);
    chk(n, 3);
    chk({cycle_start, cycle_kind}, {1'b1, CYC_NOP});
    wait_ph(2'h1);
    chk(dec_out, 49'h0);
    wait_ph(2'h1);
    chk(dec_out.op, OP_CALL);
    chk({dec_out.fld.lit_wide, dec_out.fld.literal}, 12'hd55);
    wait_ph(2'h1);
    chk(cycle_kind, CYC_NOP);
    wait_ph(2'h1);
    chk(dec_out.op, OP_NOP);
    wait_ph(2'h1);
    chk(n, 4);
    chk(cycle_kind, CYC_EXEC);
  endtask

  // returns, a true skip, carry-only and zero-only flags, arithmetic into status
  task automatic t_ctrl();
    start('{14'h3455, 14'h0f05, 14'h0d85, 14'h0103, 14'h0008, 14'h0783}, 1'b1);
    chk(dec_out.op, OP_RETLW);
    chk({dec_out.wr_w, dec_out.pc_change, dec_out.fld.lit_wide, dec_out.fld.literal}, {3'b110, 11'h055});
    wait_ph(2'h1);
    chk(cycle_kind, CYC_NOP);
    wait_ph(2'h1);
    chk(dec_out.op, OP_INCFSZ);
    chk({dec_out.wr_w, dec_out.wr_file, dec_out.cond_skip}, 3'b101);
    wait_ph(2'h1);
    chk(cycle_kind, CYC_NOP);
    wait_ph(2'h1);
    chk(dec_out.op, OP_RLF);
    chk({dec_out.flag_mask, dec_out.wr_file}, 4'h3);
    wait_ph(2'h1);
    chk(n, 4);
    chk({dec_out.op, dec_out.wr_w, dec_out.flag_mask}, {OP_CLRW, 4'hc});
    wait_ph(2'h1);
    chk({dec_out.op, dec_out.iclass, dec_out.pc_change}, {OP_RETURN, CLS_LIT, 1'b1});
    wait_ph(2'h1);
    chk(cycle_kind, CYC_NOP);
    wait_ph(2'h1);
    chk(dec_out.op, OP_ADDWF);
    chk({dec_out.status_dest, dec_out.flag_mask}, 4'hf);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cond_true = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (20) @(negedge core_clk);
    t_byte();
    t_bit();
    t_lit();
    t_ctrl();
    end_of_test();
  end
endmodule // instr_word_decoder_tb

// ### test/iwd_prog_mem.sv
`timescale 1ns/10ps

`include "iwd_params.svh"

module iwd_prog_mem
  import iwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] phase_out,
  input wire iwd_cyc_t cycle_kind,
  output logic [`IWD_WORD_W-1:0] instr_word
);
  logic [`IWD_WORD_W-1:0] mem [0:15];
  logic [3:0] ptr_reg;

  // ----------------------------------------------------------------
  // fetch pointer
  // ----------------------------------------------------------------
  // advance only after a word was taken in an execute cycle; a word offered
  // in a forced no-op cycle is dropped by the core, so it is offered again
  always @(negedge core_clk) begin
    if (!rst_n) begin
      ptr_reg <= 4'h0;
    end else if (phase_out == 2'h1 && cycle_kind == CYC_EXEC) begin
      ptr_reg <= ptr_reg + 4'h1;
    end
  end

  // word valid in phase 0 only; inverse elsewhere so a late sample shows up
  assign instr_word = (phase_out == 2'h0) ? mem[ptr_reg] : ~mem[ptr_reg];
endmodule // iwd_prog_mem
